// ===== rtl/tone_timer_regs.vh
// Command codes, bit positions, reset values and timing constants of the tone timer block
`ifndef TONE_TIMER_REGS_VH
`define TONE_TIMER_REGS_VH

// Serial command codes
`define CMD_GENERAL_RESET   8'h01
`define CMD_WRITE_CONTROL   8'h30
`define CMD_READ_STATUS     8'h31
`define CMD_NOTONE_TIMER    8'h33
`define CMD_TONE_GEN1       8'h34
`define CMD_TONE_GEN2       8'h35
`define CMD_GENERAL_TIMER   8'h36

// Data bytes that follow each command
`define BYTES_NONE          2'd0
`define BYTES_ONE           2'd1
`define BYTES_TWO           2'd2

// Status bits
`define ST_MEAS_DONE        0
`define ST_NOTONE           1
`define ST_GP_EXPIRED       2

// Control bits
`define CTRL_BAND_HI        1
`define CTRL_BAND_LO        0
`define CTRL_RX_IRQ_EN      5
`define CTRL_GP_IRQ_EN      6

// Band codes and reset values
`define BAND_HIGH           2'b00
`define BAND_MID            2'b01
`define CONTROL_RESET       8'h00
`define TIMER_RESET         4'h0
`define TONE_RESET          16'h0000
`define STATUS_RESET        3'b000

// Timer units in milliseconds
`define GP_UNIT_FAST_MS     10'd10
`define GP_UNIT_MID_MS      10'd20
`define NT_UNIT_FAST_MS     10'd20
`define NT_UNIT_MID_MS      10'd40

// Clock rate and timer tick
`define CLK_FREQ_HZ         200000000
`define TICK_TIME_MS        1
`define TICK_CYCLES         (`CLK_FREQ_HZ / 1000 * `TICK_TIME_MS)

// Serial framing
`define LAST_BIT            3'd7
`define REPLY_FALLS         4'd9
`define REPLY_SKIP          4'd9

`endif

// ===== rtl/tone_timer_interrupt_logic.v
// Serial command slave, timers, status and interrupt logic of the tone signalling processor
`timescale 1ns/1ps
// Functional notes
// R1: Notone expiry during a measurement over 75% done is held back unless aborted.
// R2: General timer is written with command 36h and one data byte.
// R3: Host keeps timer byte bits 7..4 zero; period code sits in 3..0.
// R4: Period is code times 10 ms (high/extended) or 20 ms (mid); zero stops.
// R5: After the timer byte the general timer restarts with the new period.
// R6: General timer expiry sets status bit 2 and the interrupt if enabled.
// R7: General expiry flag clears on status read, new timer byte, general reset.
// R8: General timer reloads itself after expiry until rewritten or reset.
// R9: General expiry flag and interrupt stay set across reloads until cleared.
// R10: General reset loads the general timer with zero.
// R11: All-zero tone generator word puts that encoder into powersave.
// R12: Summing amplifier powersaves when both encoders powersave.
// R13: Clock and serial interface stay active in every powersave state.
// R14: Notone interrupt enabled by control bit 5, reported in status bit 1.
// R15: General timer interrupt enabled by control bit 6, flag in status bit 2.
// R16: Successful measurement sets status bit 0, interrupt enabled by control bit 5.
// R17: Read status drops the interrupt, shifts status out, then clears it.
// R18: General reset 01h: high band, interrupts off, both timers zero.
// R19: Host issues general reset at power-up and sets timers before enabling.
// R20: Host receive sequence: control, prime notone, enable, read status then result.
// R21: Measurement interrupts repeat per measurement; notone interrupt once tone is lost.
// R22: Host transmit sequence: bias tones, control, load timer, enable, reload per expiry.
// R23: Notone timer written by 33h plus byte: code times 20 ms or 40 ms mid.
// R24: Notone timer is one-shot, restarted only by successful measurements.
// R25: Notone flag clears on status read, new notone byte, general reset.
// R26: Interrupt request is active while any enabled status flag is set.
`include "tone_timer_regs.vh"
module tone_timer_interrupt_logic #(
  parameter [31:0] TICK_CYCLES = `TICK_CYCLES
) (
  input  wire        clk,
  input  wire        reset,
  input  wire        bus_csn,
  input  wire        bus_sclk,
  input  wire        bus_cmd_data,
  output reg         bus_reply_data,
  output reg         bus_reply_oe_n,
  output reg         irq_n,
  input  wire        meas_done,
  input  wire        meas_late,
  input  wire        meas_abort,
  output reg  [7:0]  control,
  output reg  [15:0] tone1_word,
  output reg  [15:0] tone2_word,
  output reg         enc1_powersave,
  output reg         enc2_powersave,
  output reg         sum_amp_powersave
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers and serial clock edges
reg  [2:0] pin_s1;
reg  [2:0] pin_s2;
reg        sclk_d;
wire       csn_s   = pin_s2[2];
wire       sclk_s  = pin_s2[1];
wire       din_s   = pin_s2[0];
wire       sclk_rise = sclk_s & ~sclk_d & ~csn_s;
wire       sclk_fall = ~sclk_s & sclk_d & ~csn_s;
// Chip select resets high, which gates off any false edge after reset

always @(posedge clk) begin
  if (reset) begin
    pin_s1 <= 3'b110;
    pin_s2 <= 3'b110;
    sclk_d <= 1'b1;
  end else begin
    pin_s1 <= {bus_csn, bus_sclk, bus_cmd_data};
    pin_s2 <= pin_s1;
    sclk_d <= sclk_s;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Byte assembly and command decode
reg  [2:0] bit_cnt;
reg  [6:0] shift_in;
reg  [1:0] bytes_left;
reg  [7:0] cur_cmd;
reg  [7:0] data_hi;
wire       byte_done = sclk_rise & (bit_cnt == `LAST_BIT);
wire [7:0] rx_byte   = {shift_in, din_s};
wire       is_addr   = (bytes_left == `BYTES_NONE);
wire       last_data = byte_done & (bytes_left == `BYTES_ONE);

wire gen_reset   = byte_done & is_addr & (rx_byte == `CMD_GENERAL_RESET);     // R18
wire status_read = byte_done & is_addr & (rx_byte == `CMD_READ_STATUS);       // R17
wire ctrl_wr     = last_data & (cur_cmd == `CMD_WRITE_CONTROL);
wire nt_wr       = last_data & (cur_cmd == `CMD_NOTONE_TIMER);                // R23
wire gp_wr       = last_data & (cur_cmd == `CMD_GENERAL_TIMER);               // R2
wire t1_wr       = last_data & (cur_cmd == `CMD_TONE_GEN1);
wire t2_wr       = last_data & (cur_cmd == `CMD_TONE_GEN2);

reg  [1:0] addr_bytes;
always @* begin
  case (rx_byte)
    `CMD_WRITE_CONTROL,
    `CMD_NOTONE_TIMER,
    `CMD_GENERAL_TIMER: addr_bytes = `BYTES_ONE;
    `CMD_TONE_GEN1,
    `CMD_TONE_GEN2:     addr_bytes = `BYTES_TWO;
    default:            addr_bytes = `BYTES_NONE;
  endcase
end

// A raised chip select abandons any partial byte or command
// No powersave state reaches this logic, so the bus always answers
always @(posedge clk) begin
  if (reset || csn_s) begin
    bit_cnt    <= 3'd0;
    shift_in   <= 7'h00;
    bytes_left <= `BYTES_NONE;
    cur_cmd    <= 8'h00;
    data_hi    <= 8'h00;
  end else if (sclk_rise) begin                                             // R13
    bit_cnt  <= bit_cnt + 3'd1;
    shift_in <= rx_byte[6:0];
    if (byte_done) begin
      if (is_addr) begin
        cur_cmd    <= rx_byte;
        bytes_left <= addr_bytes;
      end else begin
        bytes_left <= bytes_left - 2'd1;
        data_hi    <= rx_byte;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Control, tone words and powersave
reg  [3:0] gp_code;
reg  [3:0] nt_code;
wire       mid_band = (control[`CTRL_BAND_HI:`CTRL_BAND_LO] == `BAND_MID);

always @(posedge clk) begin
  if (reset || gen_reset) begin
    control <= `CONTROL_RESET;                                              // R18
    gp_code <= `TIMER_RESET;                                                // R10
    nt_code <= `TIMER_RESET;
  end else begin
    if (ctrl_wr)
      control <= rx_byte;
    if (gp_wr)
      gp_code <= rx_byte[3:0];                                              // R3
    if (nt_wr)
      nt_code <= rx_byte[3:0];
  end
end

// Tone words survive a general reset; only power-up clears them
always @(posedge clk) begin
  if (reset) begin
    tone1_word        <= `TONE_RESET;
    tone2_word        <= `TONE_RESET;
    enc1_powersave    <= 1'b1;
    enc2_powersave    <= 1'b1;
    sum_amp_powersave <= 1'b1;
  end else begin
    if (t1_wr)
      tone1_word <= {data_hi, rx_byte};
    if (t2_wr)
      tone2_word <= {data_hi, rx_byte};
    enc1_powersave    <= (tone1_word == `TONE_RESET);                        // R11
    enc2_powersave    <= (tone2_word == `TONE_RESET);                        // R11
    sum_amp_powersave <= enc1_powersave & enc2_powersave;                   // R12
  end
end

////////////////////////////////////////////////////////////////////////////////
// Timers, one millisecond prescaler each so a reload starts a full tick
wire [9:0] gp_unit = mid_band ? `GP_UNIT_MID_MS : `GP_UNIT_FAST_MS;
wire [9:0] nt_unit = mid_band ? `NT_UNIT_MID_MS : `NT_UNIT_FAST_MS;
wire [9:0] gp_load = {6'h00, gp_code} * gp_unit;                            // R4
wire [9:0] nt_load = {6'h00, nt_code} * nt_unit;                            // R23

reg  [31:0] gp_pre;
reg  [9:0]  gp_cnt;
reg  [31:0] nt_pre;
reg  [9:0]  nt_cnt;
reg         nt_run;
reg         nt_pending;
wire        gp_tick   = (gp_pre == TICK_CYCLES - 32'd1);
wire        nt_tick   = (nt_pre == TICK_CYCLES - 32'd1);
wire        gp_expire = gp_tick & (gp_cnt == 10'd1);
wire        nt_expire = nt_run & nt_tick & (nt_cnt == 10'd1);
wire        nt_report = (nt_expire & ~meas_late) | (nt_pending & meas_abort); // R1

// Period code zero leaves the counter at zero, so it never expires
always @(posedge clk) begin
  if (reset || gen_reset) begin
    gp_pre <= 32'd0;
    gp_cnt <= 10'd0;                                                        // R10
  end else if (gp_wr) begin
    gp_pre <= 32'd0;                                                        // R5
    gp_cnt <= {6'h00, rx_byte[3:0]} * gp_unit;                              // R5
  end else if (gp_cnt != 10'd0) begin
    gp_pre <= gp_tick ? 32'd0 : gp_pre + 32'd1;
    if (gp_expire)
      gp_cnt <= gp_load;                                                    // R8
    else if (gp_tick)
      gp_cnt <= gp_cnt - 10'd1;
  end
end

always @(posedge clk) begin
  if (reset || gen_reset || nt_wr) begin
    nt_pre     <= 32'd0;
    nt_cnt     <= 10'd0;
    nt_run     <= 1'b0;
    nt_pending <= 1'b0;
  end else if (meas_done) begin
    nt_pre     <= 32'd0;                                                    // R24
    nt_cnt     <= nt_load;                                                  // R24
    nt_run     <= (nt_load != 10'd0);                                       // R24
    nt_pending <= 1'b0;                                                     // R1
  end else begin
    if (nt_run) begin
      nt_pre <= nt_tick ? 32'd0 : nt_pre + 32'd1;
      if (nt_tick)
        nt_cnt <= nt_cnt - 10'd1;
    end
    if (nt_expire)
      nt_run <= 1'b0;                                                       // R24
    if (nt_expire & meas_late)
      nt_pending <= 1'b1;                                                   // R1
    else if (meas_abort)
      nt_pending <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Status flags and interrupt; a set in the clearing cycle wins
reg  [2:0] status;
reg  [2:0] next_status;
reg  [7:0] next_control;

always @* begin
  next_status = status;
  if (status_read || gen_reset)
    next_status = `STATUS_RESET;                                            // R17
  if (gp_wr)
    next_status[`ST_GP_EXPIRED] = 1'b0;                                     // R7
  if (nt_wr)
    next_status[`ST_NOTONE] = 1'b0;                                         // R25
  // An expiry beats a same-cycle rewrite of its timer
  if (gp_expire)
    next_status[`ST_GP_EXPIRED] = 1'b1;                                     // R6 R9
  if (nt_report)
    next_status[`ST_NOTONE] = 1'b1;                                         // R14
  if (meas_done)
    next_status[`ST_MEAS_DONE] = 1'b1;                                      // R16 R21
  next_control = control;
  if (gen_reset)
    next_control = `CONTROL_RESET;
  else if (ctrl_wr)
    next_control = rx_byte;
end

always @(posedge clk) begin
  if (reset) begin
    status <= `STATUS_RESET;
    irq_n  <= 1'b1;
  end else begin
    status <= next_status;
    irq_n  <= ~(((next_status[`ST_MEAS_DONE] | next_status[`ST_NOTONE])
                 & next_control[`CTRL_RX_IRQ_EN])                           // R14 R16
               | (next_status[`ST_GP_EXPIRED]
                 & next_control[`CTRL_GP_IRQ_EN]));                         // R15 R26
  end
end

////////////////////////////////////////////////////////////////////////////////
// Status reply; the falling edge that closes the command byte is skipped
reg  [7:0] reply_sh;
reg  [3:0] reply_cnt;

always @(posedge clk) begin
  if (reset || csn_s) begin
    reply_sh       <= 8'h00;
    reply_cnt      <= 4'd0;
    bus_reply_data <= 1'b0;
    bus_reply_oe_n <= 1'b1;
  end else if (status_read) begin
    reply_sh       <= {5'h00, status};                                      // R17
    reply_cnt      <= `REPLY_FALLS;
    bus_reply_data <= 1'b0;
    bus_reply_oe_n <= 1'b0;
  end else if (sclk_fall && reply_cnt != 4'd0) begin
    reply_cnt <= reply_cnt - 4'd1;
    if (reply_cnt != `REPLY_SKIP) begin
      reply_sh       <= {reply_sh[6:0], 1'b0};
      bus_reply_data <= reply_sh[6];
    end
    bus_reply_oe_n <= (reply_cnt == 4'd1);
  end
end

endmodule // tone_timer_interrupt_logic

// ===== testbench/tone_timer_monitor.sv
// Port-level assertions and covers of the tone timer block
`timescale 1ns/1ps
module tone_timer_monitor #(
  parameter [31:0] TICK_CYCLES = 200000
) (
  input wire        clk,
  input wire        reset,
  input wire        bus_csn,
  input wire        bus_reply_data,
  input wire        bus_reply_oe_n,
  input wire        irq_n,
  input wire        meas_done,
  input wire [7:0]  control,
  input wire [15:0] tone1_word,
  input wire [15:0] tone2_word,
  input wire        enc1_powersave,
  input wire        enc2_powersave,
  input wire        sum_amp_powersave
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  chk_reset_idle:
    assert property (disable iff (1'b0) $fell(reset) |-> irq_n && bus_reply_oe_n && control == 8'h00)
    else $error("outputs not idle after reset");
  chk_enc1_save:
    assert property ($stable(tone1_word)[*3] |-> enc1_powersave == (tone1_word == 16'h0000))
    else $error("encoder 1 powersave wrong");
  chk_enc2_save:
    assert property ($stable(tone2_word)[*3] |-> enc2_powersave == (tone2_word == 16'h0000))
    else $error("encoder 2 powersave wrong");
  chk_sum_save:
    assert property ($stable(enc1_powersave && enc2_powersave)[*3]
                     |-> sum_amp_powersave == (enc1_powersave && enc2_powersave))
    else $error("summing amplifier powersave wrong");
  chk_irq_gated:
    assert property (!irq_n |-> control[5] || control[6] || $past(control[5] || control[6]))
    else $error("interrupt with no source enabled");
  chk_meas_irq:
    assert property (meas_done && control[5] |-> ##[1:2] !irq_n)
    else $error("measurement gave no interrupt");
  chk_read_irq:
    assert property ($fell(bus_reply_oe_n) |-> irq_n)
    else $error("interrupt kept on status read");
  chk_read_msb:
    assert property ($fell(bus_reply_oe_n) |-> !bus_reply_data)
    else $error("reply msb not zero");
  chk_reply_len:
    assert property ($fell(bus_reply_oe_n) |-> !bus_reply_oe_n[*8])
    else $error("reply released too early");
  chk_csn_release:
    assert property ($rose(bus_csn) |-> ##[1:4] bus_reply_oe_n)
    else $error("reply kept after deselect");
  cov_read: cover property ($fell(bus_reply_oe_n));
  cov_meas: cover property (meas_done && control[5]);
  cov_sum: cover property ($rose(sum_amp_powersave));
endmodule // tone_timer_monitor

bind tone_timer_interrupt_logic tone_timer_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon_u (
  .clk(clk), .reset(reset), .bus_csn(bus_csn), .bus_reply_data(bus_reply_data),
  .bus_reply_oe_n(bus_reply_oe_n), .irq_n(irq_n), .meas_done(meas_done), .control(control),
  .tone1_word(tone1_word), .tone2_word(tone2_word), .enc1_powersave(enc1_powersave),
  .enc2_powersave(enc2_powersave), .sum_amp_powersave(sum_amp_powersave));

// ===== testbench/serial_host_model.sv
// Host side of the serial command bus
`timescale 1ns/1ps
module serial_host_model (
  output reg  bus_csn,
  output reg  bus_sclk,
  output reg  bus_cmd_data,
  input  wire bus_reply_data,
  input  wire bus_reply_oe_n
);
  initial begin
    bus_csn = 1'b1;
    bus_sclk = 1'b0;
    bus_cmd_data = 1'b0;
  end
  // Data moves while clock low; reply taken at the rise, unknown if not driven
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bus_cmd_data = tx[i];
        #24 bus_sclk = 1'b1;
        rx[i] = bus_reply_oe_n ? 1'bx : bus_reply_data;
        #24 bus_sclk = 1'b0;
      end
    end
  endtask
  // Command then its data bytes, high byte first, in one frame
  task send(input [7:0] c, input [15:0] d, input [1:0] k, output [7:0] rx);
    reg [7:0] junk;
    begin
      bus_csn = 1'b0;
      #24 xfer(c, junk);
      if (k == 2'd2) xfer(d[15:8], junk);
      if (k != 2'd0) xfer(d[7:0], rx);
      #24 bus_csn = 1'b1;
      // Released line must not keep showing the last bit
      bus_cmd_data = ~bus_cmd_data;
      #48;
    end
  endtask
endmodule // serial_host_model

// ===== testbench/tone_timer_interrupt_logic_bench.sv
// Self-checking bench of the tone timer block
`timescale 1ns/1ps
`include "tone_timer_regs.vh"
`define CHK(nm, e, g) begin checks = checks + 1; if ((g) !== (e)) begin errors = errors + 1; \
  $display("FAIL %s exp %h got %h", nm, e, g); end end
module tone_timer_interrupt_logic_bench;
  localparam TICK = 20;
  reg         clk = 1'b0, reset = 1'b1, meas_done = 1'b0, meas_late = 1'b0, meas_abort = 1'b0;
  wire        bus_csn, bus_sclk, bus_cmd_data, bus_reply_data, bus_reply_oe_n, irq_n;
  wire        enc1_powersave, enc2_powersave, sum_amp_powersave;
  wire [7:0]  control;
  wire [15:0] tone1_word, tone2_word;
  integer     errors = 0, checks = 0, cyc = 0, n, b, g;
  reg  [31:0] seed = 32'h000137D2;
  reg  [15:0] t;
  always #2.5 clk = ~clk;
  tone_timer_interrupt_logic #(.TICK_CYCLES(TICK)) dut_u (.clk(clk), .reset(reset), .bus_csn(bus_csn),
    .bus_sclk(bus_sclk), .bus_cmd_data(bus_cmd_data), .bus_reply_data(bus_reply_data),
    .bus_reply_oe_n(bus_reply_oe_n), .irq_n(irq_n), .meas_done(meas_done), .meas_late(meas_late),
    .meas_abort(meas_abort), .control(control), .tone1_word(tone1_word), .tone2_word(tone2_word),
    .enc1_powersave(enc1_powersave), .enc2_powersave(enc2_powersave), .sum_amp_powersave(sum_amp_powersave));
  serial_host_model host_u (.bus_csn(bus_csn), .bus_sclk(bus_sclk), .bus_cmd_data(bus_cmd_data),
    .bus_reply_data(bus_reply_data), .bus_reply_oe_n(bus_reply_oe_n));
  ////////////////////////////////////////////////////////////////////////////
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function integer gp_cycles(input [3:0] c, input integer mid);
    gp_cycles = c * (mid ? 20 : 10) * TICK;
  endfunction
  task wr(input [7:0] c, input [15:0] d, input [1:0] k);
    reg [7:0] r;
    host_u.send(c, d, k, r);
  endtask
  task rd(input [7:0] e);
    reg [7:0] r;
    begin
      host_u.send(`CMD_READ_STATUS, 16'h0000, `BYTES_ONE, r);
      `CHK("status", e, r)
    end
  endtask
  task wait_irq(input integer lim);
    for (n = 0; irq_n !== 1'b0 && n < lim; n = n + 1) @(negedge clk);
  endtask
  task pulse(input integer abort);
    begin
      @(negedge clk);
      if (abort) meas_abort = 1'b1; else meas_done = 1'b1;
      @(negedge clk);
      meas_done = 1'b0;
      meas_abort = 1'b0;
    end
  endtask
  task summarize;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Longest path is the mid band timer pass, about 9k cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      errors = errors + 1;
      summarize;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(negedge clk);
    reset = 1'b0;
    `CHK("irq_idle", 1'b1, irq_n)
    `CHK("ps_reset", 3'b111, {enc1_powersave, enc2_powersave, sum_amp_powersave})
    wr(`CMD_GENERAL_RESET, 16'h0000, `BYTES_NONE);
    for (b = 0; b < 2; b = b + 1) begin
      seed = lfsr(seed);
      g = gp_cycles({2'b01, seed[1:0]}, b);
      wr(`CMD_WRITE_CONTROL, {8'h00, 8'h40 | b[7:0]}, `BYTES_ONE);
      `CHK("control", 8'h40 | b[7:0], control)
      wr(`CMD_GENERAL_TIMER, {12'h000, 2'b01, seed[1:0]}, `BYTES_ONE);
      wait_irq(g + 20);
      `CHK("gp_time", 1'b1, n + 30 >= g && n <= g)
      repeat (g * 3 / 2) @(negedge clk);
      `CHK("gp_hold", 1'b0, irq_n)
      rd(8'h04);
      `CHK("irq_clr", 1'b1, irq_n)
      wait_irq(g);
      `CHK("gp_reload", 1'b1, n < g / 2)
    end
    wr(`CMD_GENERAL_RESET, 16'h0000, `BYTES_NONE);
    `CHK("ctl_reset", 8'h00, control)
    rd(8'h00);
    wr(`CMD_WRITE_CONTROL, 16'h0040, `BYTES_ONE);
    wait_irq(3000);
    `CHK("gp_zero", 3000, n)
    $display("test gp_timer done");
    wr(`CMD_WRITE_CONTROL, 16'h0020, `BYTES_ONE);
    wr(`CMD_NOTONE_TIMER, 16'h0001, `BYTES_ONE);
    pulse(0);
    wait_irq(4);
    `CHK("meas_irq", 1'b0, irq_n)
    rd(8'h01);
    wait_irq(600);
    rd(8'h02);
    wait_irq(600);
    `CHK("one_shot", 600, n)
    pulse(0);
    rd(8'h01);
    meas_late = 1'b1;
    wait_irq(600);
    `CHK("late_hold", 600, n)
    pulse(1);
    meas_late = 1'b0;
    rd(8'h02);
    pulse(0);
    repeat (500) @(negedge clk);
    wr(`CMD_NOTONE_TIMER, 16'h0001, `BYTES_ONE);
    rd(8'h01);
    $display("test notone done");
    seed = lfsr(seed);
    t = seed[15:0] | 16'h2000;
    wr(`CMD_TONE_GEN1, t, `BYTES_TWO);
    wr(`CMD_TONE_GEN2, ~t | 16'h2000, `BYTES_TWO);
    `CHK("tone1", t, tone1_word)
    `CHK("tone2", ~t | 16'h2000, tone2_word)
    `CHK("ps_on", 3'b000, {enc1_powersave, enc2_powersave, sum_amp_powersave})
    wr(`CMD_TONE_GEN1, 16'h0000, `BYTES_TWO);
    `CHK("ps_one", 3'b100, {enc1_powersave, enc2_powersave, sum_amp_powersave})
    wr(`CMD_TONE_GEN2, 16'h0000, `BYTES_TWO);
    `CHK("ps_both", 3'b111, {enc1_powersave, enc2_powersave, sum_amp_powersave})
    rd(8'h00);
    $display("test powersave done");
    summarize;
  end
endmodule // tone_timer_interrupt_logic_bench
